// File: core/dsc_strobe_ctrl.sv
// strobe group control: output enable, isi stretch, gearing clocks, read strobe
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "dsc_consts.svh"
module dsc_strobe_ctrl (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic [4:0]          wb_adr_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic                wb_we_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    output logic                     wb_ack_o,
    input  wire logic                output_enable_in_i,
    input  wire logic [10:0]         dq_out_i,
    input  wire logic [10:0]         dq_i,
    output logic      [10:0]         dq_o,
    output logic      [10:0]         dq_oe_n_o,
    input  wire logic                dqs_i,
    output logic                     dqs_o,
    output logic                     dqs_oe_n_o,
    output logic                     dqs_n_o,
    output logic                     dqs_n_oe_n_o,
    input  wire logic                read_i,
    input  wire logic [6:0]          dll_delay_code_i,
    output logic                     write_gear_clk_a_o,
    output logic                     write_gear_clk_b_o,
    output logic                     write_strobe_out_o,
    output logic                     delayed_read_strobe_o,
    output logic                     sync_clock_polarity_o,
    output logic                     gearbox_transfer_strobe_o,
    output logic      [9:0]          rd_rise_o,
    output logic      [9:0]          rd_fall_o,
    output logic                     rd_valid_o
);
    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    function automatic logic [31:0] dsc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : dsc_merge

    logic [`DSC_CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [`DSC_WLD_W-1:0]  wld_r, wld_nxt;
    logic [`DSC_ISI0_W-1:0] isi0_r, isi0_nxt;
    logic [`DSC_ISI1_W-1:0] isi1_r, isi1_nxt;
    logic                   ack_r, ack_nxt;
    logic [31:0]            rdat_r, rdat_nxt;
    logic [31:0]            stat_w;
    logic [2:0]             widx;
    logic                   wb_req;
    logic [31:0]            m;

    assign widx   = wb_adr_i[4:2];
    assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;

    always_comb begin
        ctrl_nxt = ctrl_r;
        wld_nxt  = wld_r;
        isi0_nxt = isi0_r;
        isi1_nxt = isi1_r;
        ack_nxt  = wb_req;
        rdat_nxt = rdat_r;
        m        = 32'h00000000;
        if (wb_req) begin
            if (widx == `DSC_A_CTRL) begin
                m        = dsc_merge({27'h0, ctrl_r}, wb_dat_i, wb_sel_i);
                rdat_nxt = {27'h0, ctrl_r};
                if (wb_we_i) ctrl_nxt = m[`DSC_CTRL_W-1:0];
            end else if (widx == `DSC_A_WLD) begin
                m        = dsc_merge({15'h0, wld_r}, wb_dat_i, wb_sel_i);
                rdat_nxt = {15'h0, wld_r};
                if (wb_we_i) wld_nxt = m[`DSC_WLD_W-1:0];
            end else if (widx == `DSC_A_ISI0) begin
                m        = dsc_merge({2'h0, isi0_r}, wb_dat_i, wb_sel_i);
                rdat_nxt = {2'h0, isi0_r};
                if (wb_we_i) isi0_nxt = m[`DSC_ISI0_W-1:0];
            end else if (widx == `DSC_A_ISI1) begin
                m        = dsc_merge({26'h0, isi1_r}, wb_dat_i, wb_sel_i);
                rdat_nxt = {26'h0, isi1_r};
                if (wb_we_i) isi1_nxt = m[`DSC_ISI1_W-1:0];
            end else if (widx == `DSC_A_STAT) begin
                rdat_nxt = stat_w;
            end else begin
                rdat_nxt = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= `DSC_CTRL_RST;
            wld_r  <= `DSC_WLD_RST;
            isi0_r <= 30'h00000000;
            isi1_r <= 6'h00;
            ack_r  <= 1'b0;
            rdat_r <= 32'h00000000;
        end else begin
            ctrl_r <= ctrl_nxt;
            wld_r  <= wld_nxt;
            isi0_r <= isi0_nxt;
            isi1_r <= isi1_nxt;
            ack_r  <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // ------------------------------------------------------------
    // mode limits per edge
    // ------------------------------------------------------------
    dsc_pkg::dsc_mode_type mode_eff;
    logic                  geared;
    always_comb begin
        mode_eff = dsc_pkg::dsc_mode_type'(ctrl_r[`DSC_F_MODE]);
        if (ctrl_r[`DSC_F_EDGE] == dsc_pkg::DSC_EDGE_BOT) begin
            mode_eff = dsc_pkg::DSC_MODE_SDR;
        end else if (ctrl_r[`DSC_F_EDGE] == dsc_pkg::DSC_EDGE_TOP &&
                     mode_eff == dsc_pkg::DSC_MODE_GEAR) begin
            mode_eff = dsc_pkg::DSC_MODE_DDR;
        end else if (mode_eff != dsc_pkg::DSC_MODE_DDR &&
                     mode_eff != dsc_pkg::DSC_MODE_GEAR) begin
            mode_eff = dsc_pkg::DSC_MODE_SDR;
        end
    end
    assign geared = (mode_eff == dsc_pkg::DSC_MODE_GEAR);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [6:0]  dll_m_r, dll_r;
    logic        dqs_m_r, dqs_r;
    logic [10:0] dq_m_r, dq_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dll_m_r <= 7'h00;
            dll_r   <= 7'h00;
            dqs_m_r <= 1'b1;
            dqs_r   <= 1'b1;
            dq_m_r  <= 11'h000;
            dq_r    <= 11'h000;
        end else begin
            dll_m_r <= dll_delay_code_i;
            dll_r   <= dll_m_r;
            dqs_m_r <= dqs_i;
            dqs_r   <= dqs_m_r;
            dq_m_r  <= dq_i;
            dq_r    <= dq_m_r;
        end
    end

    // ------------------------------------------------------------
    // write gearing clocks and write strobe
    // ------------------------------------------------------------
    logic [1:0] gcnt_r, gcnt_nxt;
    logic [1:0] ph_r, ph_nxt;
    logic       wstr_r, wstr_nxt;
    logic [7:0] wl_sel;
    logic [7:0] wl_sum;
    logic       gear_a, gear_b;
    always_comb begin
        wl_sel   = wld_r[`DSC_F_WLSEL] ? wld_r[`DSC_F_WLSTAT]
                                       : wld_r[`DSC_F_WLDYN];
        wl_sum   = 8'({1'b0, dll_r} + {1'b0, wl_sel[`DSC_F_WLSTEP]});
        gcnt_nxt = 2'(gcnt_r + 2'h1);
        ph_nxt   = ph_r;
        if (gcnt_r == 2'h3) begin
            ph_nxt = 2'(wl_sum[7:6] +
                       (wl_sel[`DSC_F_WLINV] ? `DSC_HALF_PH : 2'h0));
        end
        gear_a   = (gcnt_r == ph_r);
        gear_b   = (gcnt_r == 2'(ph_r + `DSC_HALF_PH));
        wstr_nxt = wstr_r;
        if (gear_a) wstr_nxt = 1'b1;
        if (gear_b) wstr_nxt = 1'b0;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gcnt_r <= 2'h0;
            ph_r   <= 2'h0;
            wstr_r <= 1'b0;
        end else begin
            gcnt_r <= gcnt_nxt;
            ph_r   <= ph_nxt;
            wstr_r <= wstr_nxt;
        end
    end
    assign write_gear_clk_a_o = gear_a;
    assign write_gear_clk_b_o = gear_b;
    assign write_strobe_out_o = wstr_r;

    // ------------------------------------------------------------
    // output enable and isi stretch
    // ------------------------------------------------------------
    logic                  oe1_r, oe1_nxt, oe2_r, oe2_nxt;
    logic [`DSC_NPIN-1:0]  pin_d;
    logic [2:0]            hist_r [`DSC_NPIN];
    logic [2:0]            hist_nxt [`DSC_NPIN];
    logic [2:0]            scnt_r [`DSC_NPIN];
    logic [2:0]            scnt_nxt [`DSC_NPIN];
    logic [`DSC_NPIN-1:0]  out_r, out_nxt;
    logic [`DSC_ISI_W-1:0] isi_v;
    logic                  drive;
    assign pin_d = {wstr_r, dq_out_i};
    always_comb begin
        oe1_nxt = output_enable_in_i;
        oe2_nxt = oe2_r;
        if (gear_a || gear_b) oe2_nxt = oe1_r;
        isi_v   = 3'h0;
        for (int p = 0; p < `DSC_NPIN; p++) begin
            if (p < `DSC_ISI_PER) begin
                isi_v = isi0_r[p*`DSC_ISI_W +: `DSC_ISI_W];
            end else begin
                isi_v = isi1_r[(p-`DSC_ISI_PER)*`DSC_ISI_W +: `DSC_ISI_W];
            end
            hist_nxt[p] = {hist_r[p][1:0], pin_d[p]};
            scnt_nxt[p] = scnt_r[p];
            out_nxt[p]  = hist_r[p][0];
            if (scnt_r[p] != 3'h0) begin
                scnt_nxt[p] = 3'(scnt_r[p] - 3'h1);
                out_nxt[p]  = out_r[p];
                hist_nxt[p] = hist_r[p];
            end else if (geared && isi_v != 3'h0 &&
                         hist_r[p][2] != hist_r[p][1] &&
                         hist_r[p][0] != hist_r[p][1]) begin
                scnt_nxt[p] = isi_v;
                out_nxt[p]  = hist_r[p][1];
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oe1_r <= 1'b0;
            oe2_r <= 1'b0;
            out_r <= 12'h000;
            for (int p = 0; p < `DSC_NPIN; p++) begin
                hist_r[p] <= 3'h0;
                scnt_r[p] <= 3'h0;
            end
        end else begin
            oe1_r <= oe1_nxt;
            oe2_r <= oe2_nxt;
            out_r <= out_nxt;
            for (int p = 0; p < `DSC_NPIN; p++) begin
                hist_r[p] <= hist_nxt[p];
                scnt_r[p] <= scnt_nxt[p];
            end
        end
    end
    assign drive        = geared ? oe2_r : oe1_r;
    assign dq_o         = out_r[`DSC_NDQ-1:0];
    assign dq_oe_n_o    = {`DSC_NDQ{~drive}};
    assign dqs_o        = out_r[`DSC_NPIN-1];
    assign dqs_oe_n_o   = ~drive;
    assign dqs_n_o      = ~out_r[`DSC_NPIN-1];
    assign dqs_n_oe_n_o = ~(drive && ctrl_r[`DSC_F_DIFF]);

    // ------------------------------------------------------------
    // read strobe delay, polarity and transfer strobe
    // ------------------------------------------------------------
    dsc_pkg::dsc_rd_type rst_st_r, rst_st_nxt;
    logic [`DSC_DLY_D-1:0] dly_r, dly_nxt;
    logic [1:0]  tap_r, tap_nxt;
    logic        dstr_r, dstr_nxt, pol_r, pol_nxt, tog_r, tog_nxt;
    logic        xfer_r, xfer_nxt, dprev_r;
    logic [9:0]  rise_r, rise_nxt, fall_r, fall_nxt;
    logic        val_r, val_nxt;
    logic        dqs_rise, d_rise, d_fall;
    assign dqs_rise = dqs_r && !dly_r[0];
    assign d_rise   = dstr_r && !dprev_r;
    assign d_fall   = !dstr_r && dprev_r;
    always_comb begin
        dly_nxt  = {dly_r[`DSC_DLY_D-2:0], dqs_r};
        tap_nxt  = tap_r;
        if (!dstr_r && !dly_r[tap_r]) tap_nxt = 2'(dll_r[6:5] + 2'(`DSC_QTR_CYC) - 2'h1);
        dstr_nxt = dly_r[tap_r] && (rst_st_r == dsc_pkg::DSC_RD_BURST);
        rst_st_nxt = rst_st_r;
        pol_nxt  = pol_r;
        tog_nxt  = tog_r;
        xfer_nxt = 1'b0;
        rise_nxt = rise_r;
        fall_nxt = fall_r;
        val_nxt  = 1'b0;
        case (rst_st_r)
            dsc_pkg::DSC_RD_IDLE: begin
                if (read_i && mode_eff != dsc_pkg::DSC_MODE_SDR) begin
                    rst_st_nxt = dsc_pkg::DSC_RD_PRE;
                end
            end
            dsc_pkg::DSC_RD_PRE: begin
                if (!read_i) rst_st_nxt = dsc_pkg::DSC_RD_IDLE;
                else if (!dqs_r) rst_st_nxt = dsc_pkg::DSC_RD_RISE;
            end
            dsc_pkg::DSC_RD_RISE: begin
                if (!read_i) begin
                    rst_st_nxt = dsc_pkg::DSC_RD_IDLE;
                end else if (dqs_rise) begin
                    rst_st_nxt = dsc_pkg::DSC_RD_BURST;
                    pol_nxt    = gcnt_r[1];
                    tog_nxt    = 1'b0;
                end
            end
            dsc_pkg::DSC_RD_BURST: begin
                if (!read_i) rst_st_nxt = dsc_pkg::DSC_RD_IDLE;
            end
            default: rst_st_nxt = dsc_pkg::DSC_RD_IDLE;
        endcase
        if (d_rise) begin
            rise_nxt = dq_r[9:0];
            tog_nxt  = ~tog_r;
            xfer_nxt = geared && tog_r;
        end
        if (d_fall) begin
            fall_nxt = dq_r[9:0];
            val_nxt  = 1'b1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_st_r <= dsc_pkg::DSC_RD_IDLE;
            dly_r    <= {`DSC_DLY_D{1'b1}};
            tap_r    <= 2'h0;
            dstr_r   <= 1'b0;
            dprev_r  <= 1'b0;
            pol_r    <= 1'b0;
            tog_r    <= 1'b0;
            xfer_r   <= 1'b0;
            rise_r   <= 10'h000;
            fall_r   <= 10'h000;
            val_r    <= 1'b0;
        end else begin
            rst_st_r <= rst_st_nxt;
            dly_r    <= dly_nxt;
            tap_r    <= tap_nxt;
            dstr_r   <= dstr_nxt;
            dprev_r  <= dstr_r;
            pol_r    <= pol_nxt;
            tog_r    <= tog_nxt;
            xfer_r   <= xfer_nxt;
            rise_r   <= rise_nxt;
            fall_r   <= fall_nxt;
            val_r    <= val_nxt;
        end
    end
    assign delayed_read_strobe_o     = dstr_r;
    assign sync_clock_polarity_o     = pol_r;
    assign gearbox_transfer_strobe_o = xfer_r;
    assign rd_rise_o  = rise_r;
    assign rd_fall_o  = fall_r;
    assign rd_valid_o = val_r;
    assign stat_w = {18'h0, dll_r, rst_st_r, tog_r, pol_r, mode_eff, drive};

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_oe_single: assert property (@(posedge clk_i) disable iff (rst_i)
        !geared && $past(!geared) |-> dqs_oe_n_o == !$past(output_enable_in_i))
        else $error("single stage output enable wrong");
    a_oe_geared: assert property (@(posedge clk_i) disable iff (rst_i)
        geared && !$past(gear_a || gear_b) && $past(geared) |-> $stable(dqs_oe_n_o))
        else $error("geared enable moved without gear clock");
    a_isi_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        !geared |-> scnt_nxt[0] == 3'h0 || scnt_r[0] != 3'h0)
        else $error("stretch started outside geared mode");
    a_isi_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        scnt_r[0] != 3'h0 |=> $stable(dq_o[0]))
        else $error("stretched bit not held");
    a_isi_len: assert property (@(posedge clk_i) disable iff (rst_i)
        scnt_r[0] == 3'h0 && scnt_nxt[0] != 3'h0 |=> scnt_r[0] == isi0_r[2:0])
        else $error("stretch length differs from setting");
    a_edge_bot: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_r[`DSC_F_EDGE] == dsc_pkg::DSC_EDGE_BOT |-> mode_eff == dsc_pkg::DSC_MODE_SDR)
        else $error("ddr mode on bottom edge");
    a_edge_top: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_r[`DSC_F_EDGE] == dsc_pkg::DSC_EDGE_TOP |-> !geared)
        else $error("gearing on top edge");
    a_gear_gap: assert property (@(posedge clk_i) disable iff (rst_i)
        gear_a |=> !gear_a ##1 !gear_a ##1 !gear_a)
        else $error("gear clock spacing wrong");
    a_pol_set: assert property (@(posedge clk_i) disable iff (rst_i)
        rst_st_r == dsc_pkg::DSC_RD_RISE && read_i && dqs_rise |=> pol_r == $past(gcnt_r[1]))
        else $error("polarity not taken at first rise");
    a_xfer_mode: assert property (@(posedge clk_i) disable iff (rst_i)
        gearbox_transfer_strobe_o |-> $past(geared) && $past(d_rise))
        else $error("transfer strobe outside geared read");
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    c_read_burst: cover property (@(posedge clk_i) disable iff (rst_i)
        rst_st_r == dsc_pkg::DSC_RD_RISE ##1 rst_st_r == dsc_pkg::DSC_RD_BURST);
    c_isi_run: cover property (@(posedge clk_i) disable iff (rst_i)
        scnt_r[0] != 3'h0);
    c_xfer: cover property (@(posedge clk_i) disable iff (rst_i)
        gearbox_transfer_strobe_o);
endmodule : dsc_strobe_ctrl

// File: pkg/dsc_consts.svh
// constants for the ddr strobe and pin control block
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH
// register word indices
`define DSC_A_CTRL    3'h0
`define DSC_A_WLD     3'h1
`define DSC_A_ISI0    3'h2
`define DSC_A_ISI1    3'h3
`define DSC_A_STAT    3'h4
// group geometry
`define DSC_NPIN      12
`define DSC_NDQ       11
`define DSC_ISI_W     3
`define DSC_ISI_PER   10
// control fields
`define DSC_F_MODE    1:0
`define DSC_F_EDGE    3:2
`define DSC_F_DIFF    4
`define DSC_CTRL_W    5
`define DSC_CTRL_RST  5'h00
// write delay fields
`define DSC_F_WLDYN   7:0
`define DSC_F_WLSTAT  15:8
`define DSC_F_WLSEL   16
`define DSC_WLD_W     17
`define DSC_WLD_RST   17'h00000
`define DSC_F_WLINV   7
`define DSC_F_WLSTEP  6:0
// isi fields
`define DSC_ISI0_W    30
`define DSC_ISI1_W    6
// timing
`define DSC_CLK_NS    50
`define DSC_LINK_NS   400
`define DSC_STEP_PS   25
`define DSC_QTR_CYC   (((`DSC_LINK_NS) / 4) / (`DSC_CLK_NS))
`define DSC_DLY_D     4
`define DSC_HALF_PH   2'h2
`endif

// File: pkg/dsc_pkg.sv
// types for the ddr strobe and pin control block
package dsc_pkg;
    typedef enum logic [1:0] {
        DSC_MODE_SDR  = 2'b00,
        DSC_MODE_DDR  = 2'b01,
        DSC_MODE_GEAR = 2'b10
    } dsc_mode_type;
    typedef enum logic [1:0] {
        DSC_EDGE_LEFT  = 2'b00,
        DSC_EDGE_RIGHT = 2'b01,
        DSC_EDGE_TOP   = 2'b10,
        DSC_EDGE_BOT   = 2'b11
    } dsc_edge_type;
    typedef enum logic [1:0] {
        DSC_RD_IDLE = 2'b00,
        DSC_RD_PRE  = 2'b01,
        DSC_RD_RISE = 2'b10,
        DSC_RD_BURST = 2'b11
    } dsc_rd_type;
endpackage : dsc_pkg

// File: test/dsc_mem_model.sv
// memory-side model: drives strobe and data pins for one read burst
`timescale 1ns/1ps
module dsc_mem_model (
    input  wire logic        go_i,
    output logic             dqs_o,
    output logic [10:0]      dq_o
);
    // ----------------------------
    // read burst
    // ----------------------------
    initial begin
        dqs_o = 1'b1;
        dq_o  = 11'h2AA;
    end
    always @(posedge go_i) begin
        #160;
        dqs_o = 1'b0;
        dq_o  = ~dq_o;
        #400;
        for (int i = 0; i < 8; i++) begin
            dqs_o = ~dqs_o;
            dq_o  = dq_o + 11'h0A5;
            #200;
        end
        // released: shows the inverse of the last level
        dqs_o = ~dqs_o;
        dq_o  = ~dq_o;
    end
endmodule : dsc_mem_model

// File: test/dsc_strobe_ctrl_tb_top.sv
// self-checking bench for the strobe group control block
`timescale 1ns/1ps
module dsc_strobe_ctrl_tb_top;
    // ----------------------------
    // signals and instances
    // ----------------------------
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic        clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic        oe = 1'b0, rdw = 1'b0, go = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [3:0]  sel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat;
    logic [10:0] dqo = 11'h000, m_dq, dq_o, dq_oe_n_o;
    logic [6:0]  dll = 7'h5A;
    logic [6:0]  mt [6] = '{7'h21, 7'h42, 7'h46, 7'h2A, 7'h0D, 7'h03};
    logic        m_dqs, dqs_o, dqs_oe_n_o, ack, ga, gb, drs, tfr, val, wso, dno;
    int          failures = 0, n_compared = 0, la, na;
    wire [10:0]  dq_w  = (dq_oe_n_o & m_dq) | (~dq_oe_n_o & dq_o);
    wire         dqs_w = dqs_oe_n_o ? m_dqs : dqs_o;
    always #25 clk_i = ~clk_i;
    dsc_mem_model i_dsc_mem_model (.go_i(go), .dqs_o(m_dqs), .dq_o(m_dq));
    dsc_strobe_ctrl i_dsc_strobe_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_ack_o(ack), .output_enable_in_i(oe), .dq_out_i(dqo),
        .dq_i(dq_w), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .dqs_i(dqs_w), .dqs_o(dqs_o),
        .dqs_oe_n_o(dqs_oe_n_o), .dqs_n_o(), .dqs_n_oe_n_o(dno), .read_i(rdw),
        .dll_delay_code_i(dll), .write_gear_clk_a_o(ga), .write_gear_clk_b_o(gb),
        .write_strobe_out_o(wso), .delayed_read_strobe_o(drs), .sync_clock_polarity_o(),
        .gearbox_transfer_strobe_o(tfr), .rd_rise_o(), .rd_fall_o(), .rd_valid_o(val));
    // ----------------------------
    // tasks
    // ----------------------------
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t exp %h got %h", $time, exp, got);
        end
    endtask : chk
    task automatic test_done;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
                      input logic [31:0] m);
        int n;
        logic [31:0] q;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (!w) chk(d, q & m);
        if (n >= 20) failures++;
    endtask : wb
    task automatic interference_corrector(input logic v, input int len, input int exp);
        int n;
        n = 0;
        for (int i = 0; i < 24 + len; i++) begin
            @(posedge clk_i);
            dqo <= {11{(i >= 8 && i < 8 + len) ? v : ~v}};
            #1;
            if (i >= 4) n += int'(dq_o[0] === v);
        end
        chk(32'(exp), 32'(n));
    endtask : interference_corrector
    task automatic burst(input logic r, input int ev, input int et);
        int nv, nt, nd;
        logic p;
        nv = 0;
        nt = 0;
        nd = 0;
        p = 1'b0;
        @(posedge clk_i);
        rdw <= r;
        go <= 1'b1;
        for (int i = 0; i < 80; i++) begin
            @(posedge clk_i);
            // close the read window once all beats are in
            if (nv == ev) rdw <= 1'b0;
            #1;
            nv += int'(val === 1'b1);
            nt += int'(tfr === 1'b1);
            nd += int'(drs === 1'b1 && !p);
            p = (drs === 1'b1);
        end
        @(posedge clk_i);
        {rdw, go} <= 2'b00;
        chk(r ? 32'h4 : 32'h0, 32'(nd));
        chk(32'(ev), 32'(nv));
        chk(32'(et), 32'(nt));
    endtask : burst
    // ----------------------------
    // tests
    // ----------------------------
    initial begin
        #200000;
        failures++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 chk(32'h7FF, 32'(dq_oe_n_o));
        wb(0, 5'h00, 32'h0, ALL);
        wb(0, 5'h04, 32'h0, ALL);
        wb(1, 5'h00, ALL, 32'h0);
        wb(0, 5'h00, 32'h1F, ALL);
        wb(1, 5'h14, ALL, 32'h0);
        wb(0, 5'h14, 32'h0, ALL);
        wb(1, 5'h04, ALL, 32'h0);
        wb(0, 5'h04, 32'h1FFFF, ALL);
        sel <= 4'h1;
        wb(1, 5'h04, 32'h0, 32'h0);
        sel <= 4'hF;
        wb(0, 5'h04, 32'h1FF00, ALL);
        wb(1, 5'h04, 32'h0, 32'h0);
        wb(0, 5'h10, {18'h0, dll, 7'h0}, 32'h3F80);
        foreach (mt[k]) begin
            wb(1, 5'h00, {27'h0, mt[k][4:0]}, 32'h0);
            wb(0, 5'h10, {29'h0, mt[k][6:5], 1'b0}, 32'h6);
        end
        wb(1, 5'h00, 32'h11, 32'h0);
        @(posedge clk_i);
        oe <= 1'b1;
        #1 chk(32'h7FF, 32'(dq_oe_n_o));
        chk(32'h1, 32'(dno));
        @(posedge clk_i);
        #1 chk(32'h0, 32'(dq_oe_n_o));
        chk(32'h0, 32'(dno));
        @(posedge clk_i);
        oe <= 1'b0;
        wb(1, 5'h00, 32'h2, 32'h0);
        la = 0;
        na = 0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_i);
            #1;
            if (gb === 1'b1 && na > 0) chk(32'h2, 32'(i - la));
            if (gb === 1'b1 && na > 0) chk(32'h1, 32'(wso));
            if (ga === 1'b1) begin
                na++;
                la = i;
            end
        end
        chk(32'hA, 32'(na));
        wb(1, 5'h08, 32'h3, 32'h0);
        interference_corrector(1'b1, 1, 5);
        interference_corrector(1'b0, 1, 5);
        interference_corrector(1'b1, 8, 8);
        wb(1, 5'h08, 32'h1, 32'h0);
        interference_corrector(1'b1, 1, 3);
        wb(1, 5'h00, 32'h1, 32'h0);
        interference_corrector(1'b1, 1, 1);
        burst(1'b1, 4, 0);
        wb(1, 5'h00, 32'h2, 32'h0);
        burst(1'b1, 4, 2);
        burst(1'b0, 0, 0);
        test_done();
    end
endmodule : dsc_strobe_ctrl_tb_top
